// >>> include/ptoc_params.svh
// Purpose: named constants for the one-step offset control block
// Assumes: byte offsets are counted from the first destination address byte
// Notes:   definitions only
`ifndef PTOC_PARAMS_SVH
`define PTOC_PARAMS_SVH
`define PTOC_OP_NONE        2'b00
`define PTOC_OP_INSERT      2'b01
`define PTOC_OP_RETURN      2'b10
`define PTOC_OP_RSVD        2'b11
`define PTOC_OFS_ZERO       16'h0000
`define PTOC_TC_SLACK       16'h0022
`define PTOC_ENTRY_W        1
`define PTOC_ENTRY_DEPTH    2
`endif

// >>> include/ptoc_pkg.sv
// Purpose: shared types for the one-step offset control block
// Assumes: nothing beyond the params header
// Notes:   one descriptor travels per frame
package ptoc_pkg;
    typedef enum logic [1:0] {
        PTOC_OPNONE,
        PTOC_OPINSERT,
        PTOC_OPRETURN,
        PTOC_OPRSVD
    } ptoc_op_t;
    typedef struct packed {
        logic [1:0]  op;
        logic        csumEn;
        logic        tsEn;
        logic [15:0] tsOfs;
        logic [15:0] csumOfs;
        logic        oddErr;
        logic        tcErr;
    } ptoc_desc_t;
endpackage

// >>> include/ptoc_buf_if.sv
// Purpose: valid/ready link between the offset control and its buffer
// Assumes: single clock
// Notes:   source drives valid and data, sink drives ready
`timescale 1ns/10ps
`default_nettype none
interface ptoc_buf_if;
    import ptoc_pkg::*;
    logic       valid;
    logic       ready;
    ptoc_desc_t data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// >>> logic/ptoc_skid_buf.sv
// Purpose: two-entry buffer for frame descriptors
// Assumes: core_clk domain, ce freezes everything
// Notes:   full readiness is registered, so no combinational path ready-to-ready
`timescale 1ns/10ps
`default_nettype none
module ptoc_skid_buf
    import ptoc_pkg::*;
#(
    parameter int DEPTH = 2
) (
    // clock and reset
    input  wire logic core_clk,
    input  wire logic rst_b,
    input  wire logic ce,
    // ports
    ptoc_buf_if.snk   inPort,
    ptoc_buf_if.src   outPort
);
    ptoc_desc_t mem [DEPTH];
    logic       wrPtr, rdPtr, next_wrPtr, next_rdPtr;
    logic [1:0] count, next_count;
    logic       doWr, doRd;

    // honest full and empty
    assign inPort.ready  = (count != 2'(DEPTH));
    assign outPort.valid = (count != 2'd0);
    assign outPort.data  = mem[rdPtr];
    assign doWr = inPort.valid && inPort.ready;
    assign doRd = outPort.valid && outPort.ready;

    // pointer and fill update
    always_comb begin
        next_wrPtr = doWr ? ~wrPtr : wrPtr;
        next_rdPtr = doRd ? ~rdPtr : rdPtr;
        next_count = count + 2'(doWr) - 2'(doRd);
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            wrPtr <= 1'b0;
            rdPtr <= 1'b0;
            count <= 2'd0;
        end else if (ce) begin
            wrPtr <= next_wrPtr;
            rdPtr <= next_rdPtr;
            count <= next_count;
        end
    end

    // storage needs no reset; empty slots are never read out as valid
    always_ff @(posedge core_clk) begin
        if (ce && doWr) begin
            mem[wrPtr] <= inPort.data;
        end
    end
endmodule
`default_nettype wire

// >>> logic/ptp_tx_onestep_offset_ctrl.sv
// Purpose: per-frame one-step offset control and tag queue error flags
// Assumes: all inputs come from logic on core_clk; tx path reset is rst_b
// Notes:   descriptor is latched when frameStart meets a ready buffer
`include "ptoc_params.svh"
`timescale 1ns/10ps
`default_nettype none
module ptp_tx_onestep_offset_ctrl
    import ptoc_pkg::*;
(
    // clock, reset, enable
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    input  wire logic        ce,
    // per-frame controls from client
    input  wire logic        frameStart,
    input  wire logic [1:0]  timing_operation_select,
    input  wire logic        checksumUpdate,
    input  wire logic [15:0] checksumByteOffset,
    input  wire logic [15:0] timestamp_byte_offset,
    input  wire logic        transparentClock,
    output logic             frameReady,
    // descriptor to the insertion datapath
    output logic             descValid,
    input  wire logic        descReady,
    output logic [1:0]       descOp,
    output logic             descTsInsert,
    output logic             descCsumUpdate,
    output logic             descCaptureTs,
    output logic [15:0]      descTsOffset,
    output logic [15:0]      descCorrOffset,
    output logic [15:0]      descCsumOffset,
    output logic             descOffsetError,
    // tag queue events and sticky status
    input  wire logic        tagWriteFail,
    input  wire logic        tagReadFail,
    output logic             tagQueueWriteError,
    output logic             tagQueueReadError
);
    ptoc_buf_if bufIn ();
    ptoc_buf_if bufOut ();
    ptoc_desc_t inDesc;
    logic       isInsert, isReturn, csumUsed;
    logic       next_frameReady;
    logic       next_descValid;
    ptoc_desc_t outDesc, next_outDesc;
    logic       next_wrErr, next_rdErr;
    logic [16:0] tcLimit;

    // decode the operation; reserved code is treated as no operation
    always_comb begin
        isInsert = (timing_operation_select == `PTOC_OP_INSERT);
        isReturn = (timing_operation_select == `PTOC_OP_RETURN);
        csumUsed = isInsert && checksumUpdate;
        tcLimit  = {1'b0, checksumByteOffset} + {1'b0, `PTOC_TC_SLACK};
    end

    // build the descriptor, zeroing offsets that must be ignored
    always_comb begin
        inDesc.op      = isInsert ? `PTOC_OP_INSERT
                       : (isReturn ? `PTOC_OP_RETURN : `PTOC_OP_NONE);
        inDesc.csumEn  = csumUsed;
        inDesc.tsEn    = isInsert;
        inDesc.tsOfs   = isInsert ? timestamp_byte_offset : `PTOC_OFS_ZERO;
        inDesc.csumOfs = csumUsed ? checksumByteOffset : `PTOC_OFS_ZERO;
        // odd offsets are unsupported; flag rather than silently shift
        inDesc.oddErr  = (isInsert && timestamp_byte_offset[0])
                       || (csumUsed && checksumByteOffset[0]);
        // the client owns this limit; we only report a breach
        inDesc.tcErr   = csumUsed && transparentClock
                       && ({1'b0, timestamp_byte_offset} > tcLimit);
    end

    assign bufIn.valid = frameStart;
    assign bufIn.data  = inDesc;

    ptoc_skid_buf #(
        .DEPTH (`PTOC_ENTRY_DEPTH)
    ) u_buf (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .ce       (ce),
        .inPort   (bufIn.snk),
        .outPort  (bufOut.src)
    );

    // output stage: a register slice; descCaptureTs and descOffsetError are decoded from its flops
    assign bufOut.ready = !descValid || descReady;

    always_comb begin
        next_frameReady = bufIn.ready;
        next_descValid  = descValid;
        next_outDesc    = outDesc;
        if (bufOut.ready) begin
            next_descValid = bufOut.valid;
            if (bufOut.valid) begin
                next_outDesc = bufOut.data;
            end
        end
    end

    // sticky errors: set wins, only reset clears
    always_comb begin
        next_wrErr = tagQueueWriteError || tagWriteFail;
        next_rdErr = tagQueueReadError || tagReadFail;
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            frameReady         <= 1'b0;
            descValid          <= 1'b0;
            outDesc            <= '0;
            tagQueueWriteError <= 1'b0;
            tagQueueReadError  <= 1'b0;
        end else if (ce) begin
            frameReady         <= next_frameReady;
            descValid          <= next_descValid;
            outDesc            <= next_outDesc;
            tagQueueWriteError <= next_wrErr;
            tagQueueReadError  <= next_rdErr;
        end
    end

    // field views of the held descriptor
    always_comb begin
        descOp          = outDesc.op;
        descTsInsert    = outDesc.tsEn;
        descCsumUpdate  = outDesc.csumEn;
        descCaptureTs   = (outDesc.op != `PTOC_OP_NONE);
        descTsOffset    = outDesc.tsOfs;
        descCorrOffset  = outDesc.tsOfs;
        descCsumOffset  = outDesc.csumOfs;
        descOffsetError = outDesc.oddErr || outDesc.tcErr;
    end
endmodule
`default_nettype wire

// >>> dv/ptoc_sink_model.sv
// Purpose: insertion datapath stand-in
// Assumes: takes a word on every other edge
// Notes: stall holds ready low to fill the buffer
`timescale 1ns/10ps
`default_nettype none
module ptoc_sink_model (
    // clock and reset
    input  wire logic core_clk,
    input  wire logic rst_b,
    // handshake
    input  wire logic stall,
    output logic      descReady
);
    logic next_descReady;
    // registered, so ready never moves between edges
    always_comb next_descReady = !descReady && !stall;
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) descReady <= 1'b0;
        else descReady <= next_descReady;
    end
endmodule
`default_nettype wire

// >>> dv/ptoc_monitor.sv
// Purpose: port checker
// Assumes: ce held high
// Notes: bound to the top
`timescale 1ns/10ps
`default_nettype none
module ptoc_monitor (
    // clock and reset
    input wire logic        core_clk,
    input wire logic        rst_b,
    // descriptor
    input wire logic        descValid,
    input wire logic        descReady,
    input wire logic [1:0]  descOp,
    input wire logic        descTsInsert,
    input wire logic        descCaptureTs,
    input wire logic        descCsumUpdate,
    input wire logic [15:0] descTsOffset,
    input wire logic [15:0] descCorrOffset,
    input wire logic [15:0] descCsumOffset,
    // tag queue
    input wire logic        tagWriteFail,
    input wire logic        tagReadFail,
    input wire logic        tagQueueWriteError,
    input wire logic        tagQueueReadError
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    a_op_not_rsvd: assert property (descValid |-> descOp != 2'h3)
        else $error("reserved op out");
    a_capture_op: assert property (descValid |-> descCaptureTs == (descOp != 2'h0))
        else $error("capture wrong");
    a_ts_insert_op: assert property (descValid |-> descTsInsert == (descOp == 2'h1))
        else $error("ts insert wrong");
    a_csum_insert_only: assert property (descValid && descOp != 2'h1 |-> !descCsumUpdate)
        else $error("csum update wrong");
    a_csum_ofs_zero: assert property (descValid && !descCsumUpdate |-> descCsumOffset == 16'h0000)
        else $error("csum offset used");
    a_ts_ofs_zero: assert property (descValid && descOp != 2'h1 |-> descTsOffset == 16'h0000)
        else $error("ts offset used");
    a_corr_uses_ts: assert property (descValid |-> descCorrOffset == descTsOffset)
        else $error("corr offset wrong");
    a_desc_holds: assert property (descValid && !descReady |=> descValid && $stable(descTsOffset))
        else $error("desc moved");
    a_wr_flag_set: assert property (tagWriteFail |=> tagQueueWriteError [*3])
        else $error("write flag lost");
    a_rd_flag_set: assert property (tagReadFail |=> tagQueueReadError [*3])
        else $error("read flag lost");
endmodule
`default_nettype wire
bind ptp_tx_onestep_offset_ctrl ptoc_monitor mon (.core_clk, .rst_b, .descValid, .descReady,
    .descOp, .descTsInsert, .descCaptureTs, .descCsumUpdate, .descTsOffset, .descCorrOffset,
    .descCsumOffset,
    .tagWriteFail, .tagReadFail, .tagQueueWriteError, .tagQueueReadError);

// >>> dv/ptp_tx_onestep_offset_ctrl_bench.sv
// Purpose: offset control bench
// Assumes: ce held high
// Notes: expected words queued at send
`timescale 1ns/10ps
`default_nettype none
module ptp_tx_onestep_offset_ctrl_bench;
    logic core_clk = 0, rst_b = 0, frameStart = 0, checksumUpdate = 0, transparentClock = 0;
    logic tagWriteFail = 0, tagReadFail = 0, stall = 0, frameReady, descValid, descReady;
    logic [1:0] timing_operation_select = 0, descOp;
    logic [15:0] checksumByteOffset = 0, timestamp_byte_offset = 0;
    logic [15:0] descTsOffset, descCorrOffset, descCsumOffset;
    logic descTsInsert, descCsumUpdate, descCaptureTs, descOffsetError;
    logic tagQueueWriteError, tagQueueReadError;
    logic [35:0] expq[$];
    int mismatches = 0, total_checks = 0, cycles = 0;
    always #10 core_clk = !core_clk;
    ptp_tx_onestep_offset_ctrl dut (.core_clk, .rst_b, .ce(1'b1), .frameStart,
        .timing_operation_select, .checksumUpdate, .checksumByteOffset, .timestamp_byte_offset,
        .transparentClock, .frameReady, .descValid, .descReady, .descOp, .descTsInsert,
        .descCsumUpdate, .descCaptureTs, .descTsOffset, .descCorrOffset, .descCsumOffset,
        .descOffsetError, .tagWriteFail, .tagReadFail, .tagQueueWriteError, .tagQueueReadError);
    ptoc_sink_model sink (.core_clk, .rst_b, .stall, .descReady);
    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk_desc(input logic [35:0] got, exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, exp);
        chk_desc({35'h0, got}, {35'h0, exp});
    endtask
    // reserved op folds to none; unused offsets read as zero
    function automatic logic [35:0] want(logic [1:0] o, logic u, t, logic [15:0] c, s);
        logic ins, cu;
        ins = o == 2'h1;
        cu = ins && u;
        return {o == 2'h3 ? 2'h0 : o, cu, ins ? s : 16'h0000, cu ? c : 16'h0000,
            ins && (s[0] || (cu && c[0]) || (t && cu && s > c + 16'h0022))};
    endfunction
    // hold keeps frameStart up for a back-to-back burst
    task automatic send(input logic [1:0] o, input logic u, t, input logic [15:0] c, s, bit hold);
        do @(negedge core_clk); while (frameReady !== 1'b1);
        {frameStart, timing_operation_select, checksumUpdate, transparentClock} = {1'b1, o, u, t};
        {checksumByteOffset, timestamp_byte_offset} = {c, s};
        expq.push_back(want(o, u, t, c, s));
        if (!hold) @(negedge core_clk) frameStart = 0;
    endtask
    task automatic drain(input string name);
        for (int i = 0; i < 60 && expq.size() != 0; i++) @(negedge core_clk);
        chk_bit(expq.size() == 0, 1'b1);
        $display("test %s done", name);
    endtask
    always @(negedge core_clk) if (descValid === 1'b1 && descReady === 1'b1)
        chk_desc({descOp, descCsumUpdate, descTsOffset, descCsumOffset, descOffsetError},
            expq.pop_front());
    always @(posedge core_clk) if (++cycles == 3000) begin
        mismatches++;
        complete_run();
    end
    initial begin
        repeat (8) @(negedge core_clk);
        rst_b = 1;
        for (int k = 0; k < 8; k++) send(k[2:1], k[0], 0, 16'h0030, 16'h002c, 0);
        drain("modes");
        send(1, 1, 0, 16'h0031, 16'h002c, 0);
        send(1, 0, 0, 16'h0031, 16'h002d, 0);
        send(2, 1, 0, 16'h0001, 16'h0003, 0);
        drain("odd");
        send(1, 1, 1, 16'h0040, 16'h0062, 0);
        send(1, 1, 1, 16'h0040, 16'h0064, 0);
        send(1, 1, 0, 16'h0040, 16'h0064, 0);
        drain("tc");
        stall = 1;
        for (int k = 0; k < 3; k++) send(1, 1, 0, k * 2, k * 4, k < 2);
        repeat (4) @(negedge core_clk);
        chk_bit(frameReady, 1'b0);
        stall = 0;
        drain("burst");
        tagWriteFail = 1;
        @(negedge core_clk) tagWriteFail = 0;
        repeat (5) @(negedge core_clk);
        chk_bit(tagQueueWriteError, 1'b1);
        chk_bit(tagQueueReadError, 1'b0);
        tagReadFail = 1;
        @(negedge core_clk) tagReadFail = 0;
        repeat (5) @(negedge core_clk);
        chk_bit(tagQueueReadError, 1'b1);
        rst_b = 0;
        @(negedge core_clk) rst_b = 1;
        chk_bit(tagQueueWriteError | tagQueueReadError, 1'b0);
        $display("test flags done");
        complete_run();
    end
endmodule
`default_nettype wire
